// ### verilog/prec_pkg.sv
// Constants for the receive error counter and lamp control bank
package prec_pkg;

  // Register offsets within the management register space
  localparam logic [4:0] ADDR_FALSE_CARRIER = 5'h13;
  localparam logic [4:0] ADDR_DISCONNECT = 5'h14;
  localparam logic [4:0] ADDR_ERROR_FRAME = 5'h15;
  localparam logic [4:0] ADDR_SYMBOL_ERROR = 5'h16;
  localparam logic [4:0] ADDR_EARLY_END = 5'h17;
  localparam logic [4:0] ADDR_TEN_EOF = 5'h18;
  localparam logic [4:0] ADDR_JABBER = 5'h19;
  localparam logic [4:0] ADDR_SPECIAL_LED = 5'h1B;

  // Widths
  localparam int CNT_W = 16;
  localparam int REG_W = 16;
  localparam int NUM_CNT = 7;

  // Counter slots in the bank
  localparam int IDX_FALSE_CARRIER = 0;
  localparam int IDX_DISCONNECT = 1;
  localparam int IDX_ERROR_FRAME = 2;
  localparam int IDX_SYMBOL_ERROR = 3;
  localparam int IDX_EARLY_END = 4;
  localparam int IDX_TEN_EOF = 5;
  localparam int IDX_JABBER = 6;

  // Reset and limit values of the counters
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_FULL = 16'hFFFF;

  // Special control register field positions
  localparam int SPC_PROBE_BIT = 5;
  localparam int SPC_NEW_MODE_BIT = 4;
  localparam int SPC_JAB_DIS_BIT = 3;
  localparam int SPC_LED_LSB = 0;
  localparam int SPC_LED_W = 3;

  // Special control register reset values
  localparam logic [2:0] LED_SEL_RESET = 3'h0;
  localparam logic PROBE_RESET = 1'b0;
  localparam logic JAB_DIS_RESET = 1'b0;

  // Bad symbols folded into one counted symbol error
  localparam logic [2:0] SYM_RUN_LEN = 3'h6;

  // Lamp source selections
  typedef enum logic [2:0] {
    PREC_LED_ACT_LINK,
    PREC_LED_SPD_COL,
    PREC_LED_SPD_LINK,
    PREC_LED_ACT_COL,
    PREC_LED_OFF_OFF,
    PREC_LED_OFF_ON,
    PREC_LED_ON_OFF,
    PREC_LED_ON_ON
  } prec_led_sel_e;

endpackage : prec_pkg

// ### verilog/prec_sat_counter.sv
// Saturating, clear-on-read event counter
`timescale 1ns/10ps
`default_nettype none

module prec_sat_counter (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Event and clear
  input wire logic inc,
  input wire logic clr,
  // Count
  output logic [15:0] count_q
);

  logic [15:0] count_d;

  // Next count; an event in the clearing cycle is kept as one
  always_comb begin
    count_d = count_q;
    if (clr) begin
      count_d = inc ? 16'h0001 : prec_pkg::CNT_RESET;
    end else if (inc && (count_q != prec_pkg::CNT_FULL)) begin
      count_d = count_q + 16'h0001;
    end
  end

  // Count register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= 16'h0000;
    end else if (ce) begin
      count_q <= count_d;
    end
  end

endmodule : prec_sat_counter

`default_nettype wire

// ### verilog/prec_counters.sv
// Receive error statistics counters and lamp control register bank
//
// Function
// - False carrier count, zeroed by reading it
// - Disconnect count, saturating, cleared on read
// - One count per errored frame, saturating
// - Symbol error count, saturating, cleared on read
// - Six consecutive bad symbols count once
// - Early frame end count, saturating, read-clear
// - Ten-meg end-of-frame error count, saturating
// - Jabber detection count, saturating, read-clear
// - Special control bits 15:6 read zero
`timescale 1ns/10ps
`default_nettype none

module prec_counters (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Management register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  // Hundred-meg receive events
  input wire logic rx_frame_active,
  input wire logic rx_symbol_valid,
  input wire logic rx_bad_symbol,
  input wire logic false_carrier_evt,
  input wire logic disconnect_evt,
  input wire logic early_end_evt,
  // Ten-meg events
  input wire logic ten_eof_err_evt,
  input wire logic jabber_evt,
  // Lamp sources, high while lit
  input wire logic activity_src,
  input wire logic link_src,
  input wire logic speed_src,
  input wire logic collision_src,
  // Mode strap pin
  input wire logic new_mode_strap,
  // Control outputs
  output logic probe_swap,
  output logic rx_jabber_disable,
  // Lamp pins, low while lit
  output logic activity_lamp_n,
  output logic link_lamp_n
);

  // Per-counter increment and clear strobes
  logic [6:0] cnt_inc;
  logic [6:0] cnt_clr;
  logic [15:0] cnt_val [7];

  // Symbol run tracking
  logic [2:0] sym_run_q;
  logic [2:0] sym_run_d;
  logic sym_err_pulse;

  // Errored frame tracking
  logic frame_err_q;
  logic frame_err_d;
  logic frame_err_pulse;

  // Special control register fields
  logic [2:0] led_sel_q;
  logic [2:0] led_sel_d;
  logic probe_q;
  logic probe_d;
  logic jab_dis_q;
  logic jab_dis_d;

  // Strap synchroniser and captured mode
  logic [2:0] strap_sync_q;
  logic [2:0] strap_sync_d;
  logic new_mode_q;
  logic new_mode_d;

  // Read data and lamp registers
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic act_lamp_n_q;
  logic act_lamp_n_d;
  logic link_lamp_n_q;
  logic link_lamp_n_d;

  // Read-side decode
  logic rd_sel;
  logic wr_spc;
  logic [15:0] spc_word;

  // run of six
  // Counts the first bad symbol of a run, then once more per six bad
  always_comb begin
    sym_run_d = sym_run_q;
    sym_err_pulse = 1'b0;
    if (!rx_frame_active) begin
      sym_run_d = 3'h0;
    end else if (rx_symbol_valid) begin
      if (rx_bad_symbol) begin
        sym_err_pulse = (sym_run_q == 3'h0);
        if (sym_run_q == prec_pkg::SYM_RUN_LEN - 3'h1) begin
          sym_run_d = 3'h0;
        end else begin
          sym_run_d = sym_run_q + 3'h1;
        end
      end else begin
        sym_run_d = 3'h0;
      end
    end
  end

  // Symbol run register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sym_run_q <= 3'h0;
    end else if (ce) begin
      sym_run_q <= sym_run_d;
    end
  end

  // once per frame
  // Flag holds after the first error so later ones in the frame are ignored
  always_comb begin
    frame_err_d = frame_err_q;
    frame_err_pulse = 1'b0;
    if (!rx_frame_active) begin
      frame_err_d = 1'b0;
    end else if ((sym_err_pulse || early_end_evt) && !frame_err_q) begin
      frame_err_d = 1'b1;
      frame_err_pulse = 1'b1;
    end
  end

  // Errored frame flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_err_q <= 1'b0;
    end else if (ce) begin
      frame_err_q <= frame_err_d;
    end
  end

  // Event routing into the counter slots
  always_comb begin
    cnt_inc = 7'h00;
    cnt_inc[prec_pkg::IDX_FALSE_CARRIER] = false_carrier_evt;
    cnt_inc[prec_pkg::IDX_DISCONNECT] = disconnect_evt;
    cnt_inc[prec_pkg::IDX_ERROR_FRAME] = frame_err_pulse;
    cnt_inc[prec_pkg::IDX_SYMBOL_ERROR] = sym_err_pulse;
    cnt_inc[prec_pkg::IDX_EARLY_END] = early_end_evt;
    cnt_inc[prec_pkg::IDX_TEN_EOF] = ten_eof_err_evt;
    cnt_inc[prec_pkg::IDX_JABBER] = jabber_evt;
  end

  // Clear strobes from reads of each counter address
  always_comb begin
    cnt_clr = 7'h00;
    if (reg_rd) begin
      cnt_clr[prec_pkg::IDX_FALSE_CARRIER] = (reg_addr == prec_pkg::ADDR_FALSE_CARRIER);
      cnt_clr[prec_pkg::IDX_DISCONNECT] = (reg_addr == prec_pkg::ADDR_DISCONNECT);
      cnt_clr[prec_pkg::IDX_ERROR_FRAME] = (reg_addr == prec_pkg::ADDR_ERROR_FRAME);
      cnt_clr[prec_pkg::IDX_SYMBOL_ERROR] = (reg_addr == prec_pkg::ADDR_SYMBOL_ERROR);
      cnt_clr[prec_pkg::IDX_EARLY_END] = (reg_addr == prec_pkg::ADDR_EARLY_END);
      cnt_clr[prec_pkg::IDX_TEN_EOF] = (reg_addr == prec_pkg::ADDR_TEN_EOF);
      cnt_clr[prec_pkg::IDX_JABBER] = (reg_addr == prec_pkg::ADDR_JABBER);
    end
  end

  // counters reset zero
  // One saturating counter per slot; each clears on its own read
  for (genvar i = 0; i < prec_pkg::NUM_CNT; i++) begin : g_cnt
    prec_sat_counter u_cnt (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .inc(cnt_inc[i]),
      .clr(cnt_clr[i]),
      .count_q(cnt_val[i])
    );
  end

  // Special control register next values
  assign wr_spc = reg_wr && (reg_addr == prec_pkg::ADDR_SPECIAL_LED);

  always_comb begin
    led_sel_d = led_sel_q;
    probe_d = probe_q;
    jab_dis_d = jab_dis_q;
    if (wr_spc) begin
      led_sel_d = reg_wdata[prec_pkg::SPC_LED_LSB +: prec_pkg::SPC_LED_W];
      probe_d = reg_wdata[prec_pkg::SPC_PROBE_BIT];
      jab_dis_d = reg_wdata[prec_pkg::SPC_JAB_DIS_BIT];
    end
  end

  // Special control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_sel_q <= prec_pkg::LED_SEL_RESET;
      probe_q <= prec_pkg::PROBE_RESET;
      jab_dis_q <= prec_pkg::JAB_DIS_RESET;
    end else if (ce) begin
      led_sel_q <= led_sel_d;
      probe_q <= probe_d;
      jab_dis_q <= jab_dis_d;
    end
  end

  // Strap pin sync; the first stage feeds only the second
  always_comb begin
    strap_sync_d = {strap_sync_q[1:0], new_mode_strap};
    new_mode_d = new_mode_q;
    // Change accepted only once stages two and three agree
    if (strap_sync_q[1] == strap_sync_q[2]) begin
      new_mode_d = strap_sync_q[2];
    end
  end

  // Strap synchroniser and filtered mode bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_sync_q <= 3'h0;
      new_mode_q <= 1'b0;
    end else if (ce) begin
      strap_sync_q <= strap_sync_d;
      new_mode_q <= new_mode_d;
    end
  end

  always_comb begin
    spc_word = 16'h0000;
    spc_word[prec_pkg::SPC_LED_LSB +: prec_pkg::SPC_LED_W] = led_sel_q;
    spc_word[prec_pkg::SPC_JAB_DIS_BIT] = jab_dis_q;
    spc_word[prec_pkg::SPC_NEW_MODE_BIT] = new_mode_q;
    spc_word[prec_pkg::SPC_PROBE_BIT] = probe_q;
  end

  // Read mux; data is the count before the read clears it
  always_comb begin
    rd_sel = 1'b1;
    rdata_d = rdata_q;
    unique case (reg_addr)
      prec_pkg::ADDR_FALSE_CARRIER: rdata_d = cnt_val[prec_pkg::IDX_FALSE_CARRIER];
      prec_pkg::ADDR_DISCONNECT: rdata_d = cnt_val[prec_pkg::IDX_DISCONNECT];
      prec_pkg::ADDR_ERROR_FRAME: rdata_d = cnt_val[prec_pkg::IDX_ERROR_FRAME];
      prec_pkg::ADDR_SYMBOL_ERROR: rdata_d = cnt_val[prec_pkg::IDX_SYMBOL_ERROR];
      prec_pkg::ADDR_EARLY_END: rdata_d = cnt_val[prec_pkg::IDX_EARLY_END];
      prec_pkg::ADDR_TEN_EOF: rdata_d = cnt_val[prec_pkg::IDX_TEN_EOF];
      prec_pkg::ADDR_JABBER: rdata_d = cnt_val[prec_pkg::IDX_JABBER];
      prec_pkg::ADDR_SPECIAL_LED: rdata_d = spc_word;
      default: begin
        // Other addresses belong to neighbouring register groups
        rd_sel = 1'b0;
        rdata_d = 16'h0000;
      end
    endcase
    if (!reg_rd) begin
      rdata_d = rdata_q;
    end
  end

  // Read data register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_hit = rd_sel;

  // lamp source select
  // Lamps are active low: a lit source drives the pin low
  always_comb begin
    act_lamp_n_d = 1'b1;
    link_lamp_n_d = 1'b1;
    unique case (prec_pkg::prec_led_sel_e'(led_sel_q))
      prec_pkg::PREC_LED_ACT_LINK: begin
        act_lamp_n_d = ~activity_src;
        link_lamp_n_d = ~link_src;
      end
      prec_pkg::PREC_LED_SPD_COL: begin
        act_lamp_n_d = ~speed_src;
        link_lamp_n_d = ~collision_src;
      end
      prec_pkg::PREC_LED_SPD_LINK: begin
        act_lamp_n_d = ~speed_src;
        link_lamp_n_d = ~link_src;
      end
      prec_pkg::PREC_LED_ACT_COL: begin
        act_lamp_n_d = ~activity_src;
        link_lamp_n_d = ~collision_src;
      end
      prec_pkg::PREC_LED_OFF_OFF: begin
        act_lamp_n_d = 1'b1;
        link_lamp_n_d = 1'b1;
      end
      prec_pkg::PREC_LED_OFF_ON: begin
        act_lamp_n_d = 1'b1;
        link_lamp_n_d = 1'b0;
      end
      prec_pkg::PREC_LED_ON_OFF: begin
        act_lamp_n_d = 1'b0;
        link_lamp_n_d = 1'b1;
      end
      prec_pkg::PREC_LED_ON_ON: begin
        act_lamp_n_d = 1'b0;
        link_lamp_n_d = 1'b0;
      end
    endcase
  end

  // Lamp registers; reset dark to avoid a flash at power-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_lamp_n_q <= 1'b1;
      link_lamp_n_q <= 1'b1;
    end else if (ce) begin
      act_lamp_n_q <= act_lamp_n_d;
      link_lamp_n_q <= link_lamp_n_d;
    end
  end

  // Output assignments
  assign activity_lamp_n = act_lamp_n_q;
  assign link_lamp_n = link_lamp_n_q;
  assign probe_swap = probe_q;
  assign rx_jabber_disable = jab_dis_q;

endmodule : prec_counters

`default_nettype wire

// ### verif/prec_mgmt_host.sv
// Management host model issuing register reads and writes
`timescale 1ns/10ps
`default_nettype none
module prec_mgmt_host (
  // Clock
  input wire logic clk,
  // Register port toward the bank
  output logic [4:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_hit
);
  // Idle bus from time zero
  initial begin
    {reg_addr, reg_rd, reg_wr, reg_wdata} = 23'h000000;
  end
  // Read data is registered, so take it after the strobe edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic h);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    // Decode flag follows the address, so take it before the address moves
    h = reg_hit;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
  // Released lines are scrambled, never left at the last value
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask : wr
endmodule : prec_mgmt_host
`default_nettype wire

// ### verif/prec_counters_sva.sv
// Property checker for the receive error counter bank
`timescale 1ns/10ps
`default_nettype none
module prec_counters_sva (
  // Clock, reset, enable
  input wire logic clk, rst, ce,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd, reg_wr,
  input wire logic [15:0] reg_wdata, reg_rdata,
  // Events and lamps
  input wire logic false_carrier_evt, disconnect_evt, early_end_evt,
  input wire logic ten_eof_err_evt, jabber_evt, activity_lamp_n, link_lamp_n
);
  default clocking @(posedge clk); endclocking
  // A frozen clock enable stalls everything, so it also suspends checking
  default disable iff (rst || !ce);
  // Second read of a quiet counter must find it cleared
  property p_rc(logic ev, logic [4:0] a);
    (reg_rd && reg_addr == a && !ev) ##1 !(ev || reg_rd) ##1
      (reg_rd && reg_addr == a && !ev) |=> reg_rdata == 16'h0000;
  endproperty
  chk_carrier_read_clear: assert property (p_rc(false_carrier_evt, 5'h13))
    else $error("false carrier count not cleared");
  chk_disconnect_read_clear: assert property (p_rc(disconnect_evt, 5'h14))
    else $error("disconnect count not cleared");
  chk_early_end_clear: assert property (p_rc(early_end_evt, 5'h17))
    else $error("early end count not cleared");
  chk_ten_eof_clear: assert property (p_rc(ten_eof_err_evt, 5'h18))
    else $error("end of frame count not cleared");
  chk_jabber_read_clear: assert property (p_rc(jabber_evt, 5'h19))
    else $error("jabber count not cleared");
  chk_reserved_read_zero: assert property (
    reg_rd && reg_addr == 5'h1B |=> reg_rdata[15:6] == 10'h000)
    else $error("reserved control bits not zero");
  chk_lamps_both_lit: assert property (
    reg_wr && reg_addr == 5'h1B && reg_wdata[2:0] == 3'h7 ##1 !reg_wr [*2]
      |=> !activity_lamp_n && !link_lamp_n)
    else $error("lamps not lit for select seven");
  chk_reset_leaves_idle: assert property (
    $fell(rst) |-> reg_rdata == 16'h0000 && activity_lamp_n && link_lamp_n)
    else $error("outputs not idle after reset");
  cover property (reg_rd && reg_addr == 5'h16);
  cover property (jabber_evt [*8]);
  cover property (reg_wr && reg_addr == 5'h1B);
endmodule : prec_counters_sva
bind prec_counters prec_counters_sva prec_counters_sva_i (.clk, .rst, .ce, .reg_addr,
  .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .false_carrier_evt, .disconnect_evt,
  .early_end_evt, .ten_eof_err_evt, .jabber_evt, .activity_lamp_n, .link_lamp_n);
`default_nettype wire

// ### verif/phy_receive_error_counters_bench.sv
// Self-checking bench for the receive error counter bank
`timescale 1ns/10ps
`default_nettype none
module phy_receive_error_counters_bench;
  logic clk, rst, ce, rx_frame_active, rx_symbol_valid, rx_bad_symbol, reg_rd, reg_wr;
  logic reg_hit, probe_swap, rx_jabber_disable, activity_lamp_n, link_lamp_n, strap;
  logic [4:0] reg_addr, evt;
  logic [3:0] src;
  logic [15:0] reg_wdata, reg_rdata, got;
  logic [4:0] ev_addr [5];
  int failures = 0;
  int n_compared = 0;
  prec_counters prec_counters_i (.clk, .rst, .ce, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata, .reg_hit, .rx_frame_active, .rx_symbol_valid, .rx_bad_symbol,
    .false_carrier_evt(evt[0]), .disconnect_evt(evt[1]), .early_end_evt(evt[2]),
    .ten_eof_err_evt(evt[3]), .jabber_evt(evt[4]), .activity_src(src[3]),
    .link_src(src[2]), .speed_src(src[1]), .collision_src(src[0]), .new_mode_strap(strap),
    .probe_swap, .rx_jabber_disable, .activity_lamp_n, .link_lamp_n);
  prec_mgmt_host prec_mgmt_host_i (.clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
    .reg_hit);
  // Lit state {activity, link} for a select value and sources {act, link, speed, coll}
  function automatic logic [1:0] lit(input logic [2:0] s, input logic [3:0] p);
    logic [7:0] a;
    logic [7:0] l;
    a = {4'hC, p[3], p[1], p[1], p[3]};
    l = {4'hA, p[0], p[2], p[0], p[2]};
    return {a[s], l[s]};
  endfunction : lit
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    logic hit;
    prec_mgmt_host_i.rd(a, got, hit);
    chk($sformatf("register %h", a), exp, got);
    // Only the counter block and the control register belong to this bank
    chk($sformatf("hit %h", a), {15'h0000, (a inside {[5'h13:5'h19], 5'h1B})}, {15'h0000, hit});
  endtask : rdc
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic t_reset_values;
    for (int i = 0; i < 5; i++) rdc(ev_addr[i], 16'h0000);
    rdc(5'h15, 16'h0000);
    rdc(5'h16, 16'h0000);
    rdc(5'h1B, 16'h0000);
    rdc(5'h12, 16'h0000);
  endtask : t_reset_values
  // Back-to-back pulses, then read twice
  task automatic t_counts;
    for (int i = 0; i < 5; i++) begin
      repeat (i + 2) @(negedge clk) evt[i] = 1'b1;
      @(negedge clk) evt = 5'h00;
      rdc(ev_addr[i], 16'(i + 2));
      rdc(ev_addr[i], 16'h0000);
    end
  endtask : t_counts
  task automatic frame(input int nbad, input int nearly);
    @(negedge clk) rx_frame_active = 1'b1;
    repeat (nbad) @(negedge clk) {rx_symbol_valid, rx_bad_symbol} = 2'b11;
    @(negedge clk) {rx_symbol_valid, rx_bad_symbol} = 2'b10;
    repeat (nearly) begin
      @(negedge clk) evt[2] = 1'b1;
      @(negedge clk) evt[2] = 1'b0;
    end
    @(negedge clk) {rx_frame_active, rx_symbol_valid} = 2'b00;
  endtask : frame
  // Runs of seven and six bad symbols straddle the fold boundary
  task automatic t_frames;
    frame(7, 0);
    frame(6, 2);
    frame(0, 1);
    rdc(5'h16, 16'h0003);
    rdc(5'h15, 16'h0003);
    rdc(5'h17, 16'h0003);
  endtask : t_frames
  // Events while the clock enable is low must not be counted
  task automatic t_freeze;
    @(negedge clk) {ce, evt} = 6'h01;
    repeat (3) @(negedge clk);
    {ce, evt} = 6'h20;
    rdc(5'h13, 16'h0000);
  endtask : t_freeze
  task automatic t_control;
    // Strap high so the mode bit is seen once it has passed the synchroniser
    strap = 1'b1;
    repeat (4) @(negedge clk);
    prec_mgmt_host_i.wr(5'h1B, 16'hFFFF);
    rdc(5'h1B, 16'h003F);
    chk("control pins", 16'h0003, {14'h0000, probe_swap, rx_jabber_disable});
    for (int k = 0; k < 16; k++) begin
      src = k[3] ? 4'h6 : 4'h9;
      prec_mgmt_host_i.wr(5'h1B, {13'h0000, k[2:0]});
      repeat (2) @(negedge clk);
      chk("lamps", {14'h0000, ~lit(k[2:0], src)}, {14'h0000, activity_lamp_n, link_lamp_n});
    end
    strap = 1'b0;
  endtask : t_control
  // Reset in mid-run drops a pending count and the select
  task automatic t_rereset;
    @(negedge clk) evt[1] = 1'b1;
    @(negedge clk) {rst, evt} = 6'h20;
    @(negedge clk) rst = 1'b0;
    rdc(5'h14, 16'h0000);
    rdc(5'h1B, 16'h0000);
  endtask : t_rereset
  task automatic t_saturate;
    @(negedge clk) evt[4] = 1'b1;
    repeat (65540) @(negedge clk);
    evt[4] = 1'b0;
    rdc(5'h19, 16'hFFFF);
    rdc(5'h19, 16'h0000);
  endtask : t_saturate
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    {rst, ce, rx_frame_active, rx_symbol_valid, rx_bad_symbol} = 5'h18;
    evt = 5'h00;
    strap = 1'b0;
    src = 4'h9;
    ev_addr = '{5'h13, 5'h14, 5'h17, 5'h18, 5'h19};
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    t_reset_values();
    t_counts();
    t_freeze();
    t_frames();
    t_control();
    t_rereset();
    t_saturate();
    give_verdict();
  end
endmodule : phy_receive_error_counters_bench
`default_nettype wire
